/* src/pps_sequencer.sv */
// Pulse program sequencer: program memory, instruction decoder and timing engine, APB slave.
// Assumes an APB master on sys_clk_i and asynchronous external trigger and reset pins.
`timescale 1ns/1ps
`include "pps_defines.svh"
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int DEPTH  = `PPS_DEPTH_DEF,
  parameter int EXTMEM = 0,
  parameter int AW     = $clog2(DEPTH)
) (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        external_trigger_in_n_i,
  input  wire logic        external_reset_in_n_i,
  output logic      [23:0] pattern_o,
  output logic             running_o,
  output logic             waiting_o,
  output logic             reset_state_o
);
  localparam logic [4:0] FETCH_CYC = (EXTMEM != 0) ? 5'(`PPS_MIN_CYC_EXT - `PPS_OVERHEAD_CYC)
                                                   : 5'(`PPS_MIN_CYC_INT - `PPS_OVERHEAD_CYC);

  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_TIME, ST_WAIT, ST_HALT} pps_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Program memory and APB slave.
  pps_word_t              mem [DEPTH];
  pps_word_t              word_r;
  logic [AW-1:0]          pc_r;
  logic [AW-1:0]          pc_nxt;
  logic [AW-1:0]          ld_addr_r;
  logic [`PPS_WORD_W-1:0] ld_word_r;
  pps_state_t             st_r;
  logic [4:0]             fcnt_r;
  logic [31:0]            dcnt_r;
  logic [19:0]            rep_r;
  logic [19:0]            loop_r;
  logic [AW-1:0]          ret_r;
  logic [23:0]            pat_r;
  logic                   rst_flag_r;
  logic                   loop_act_r;
  logic                   trig_lvl;
  logic                   trig_d_r;
  logic                   xrst_lvl;

  wire apb_wr   = psel_i && penable_i && pwrite_i;
  wire sel_ctrl = (paddr_i == `PPS_REG_CTRL);
  wire sel_stat = (paddr_i == `PPS_REG_STATUS);
  wire sel_addr = (paddr_i == `PPS_REG_PADDR);
  wire sel_pw0  = (paddr_i == `PPS_REG_PW0);
  wire sel_pw1  = (paddr_i == `PPS_REG_PW1);
  wire sel_pw2  = (paddr_i == `PPS_REG_PW2);
  wire sel_ok   = sel_ctrl | sel_stat | sel_addr | sel_pw0 | sel_pw1 | sel_pw2;
  wire sw_start = apb_wr && sel_ctrl && pwdata_i[`PPS_CTRL_START];
  wire sw_reset = apb_wr && sel_ctrl && pwdata_i[`PPS_CTRL_RESET];
  wire sw_trig  = apb_wr && sel_ctrl && pwdata_i[`PPS_CTRL_TRIG];
  wire sw_load  = apb_wr && sel_ctrl && pwdata_i[`PPS_CTRL_LOAD];

  pps_status_t stat;
  assign stat.running     = running_o;
  assign stat.waiting     = waiting_o;
  assign stat.reset_state = rst_flag_r;
  assign stat.stopped     = (st_r == ST_HALT);

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !sel_ok;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= sel_stat ? {28'h0, stat} :
                  sel_addr ? 32'(ld_addr_r) :
                  sel_pw0  ? ld_word_r[31:0] :
                  sel_pw1  ? ld_word_r[63:32] :
                  sel_pw2  ? {16'h0, ld_word_r[79:64]} : 32'h0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ld_addr_r <= '0;
      ld_word_r <= '0;
    end else if (apb_wr) begin
      if (sel_addr) ld_addr_r <= pwdata_i[AW-1:0];
      if (sel_pw0)  ld_word_r[31:0]  <= pwdata_i;
      if (sel_pw1)  ld_word_r[63:32] <= pwdata_i;
      if (sel_pw2)  ld_word_r[79:64] <= pwdata_i[15:0];
      if (sw_load)  ld_addr_r <= ld_addr_r + 1'b1;
    end
  end

  // Loading is only meant while the sequencer is not executing.
  always_ff @(posedge sys_clk_i) begin
    if (sw_load) mem[ld_addr_r] <= pps_word_t'(ld_word_r);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // External pins, active low.
  pps_pin_sync #(.RST_VAL(1'b1)) u_trig (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .pin_i     (external_trigger_in_n_i),
    .level_o   (trig_lvl)
  );
  logic xrst_n_lvl;
  pps_pin_sync #(.RST_VAL(1'b1)) u_xrst (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .pin_i     (external_reset_in_n_i),
    .level_o   (xrst_n_lvl)
  );
  assign xrst_lvl = !xrst_n_lvl;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) trig_d_r <= 1'b1;
    else           trig_d_r <= trig_lvl;
  end
  wire hw_trig = trig_d_r && !trig_lvl;
  wire trig    = hw_trig || sw_trig;
  wire rst_any = xrst_lvl || sw_reset;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoder and timing engine.
  wire pps_opcode_t opc     = pps_opcode_t'(word_r.opcode);
  wire              dly_end = (dcnt_r == 32'h0);
  wire              rep_end = (rep_r <= 20'h1);
  wire              loop_ex = (loop_r <= 20'h1);
  wire [AW-1:0]     tgt     = word_r.data[AW-1:0];

  always_comb begin
    pc_nxt = pc_r + 1'b1;
    unique case (opc)
      OP_END_LOOP: pc_nxt = loop_ex ? pc_r + 1'b1 : tgt;
      OP_CALL:     pc_nxt = tgt;
      OP_RETURN:   pc_nxt = ret_r;
      OP_BRANCH:   pc_nxt = tgt;
      default:     pc_nxt = pc_r + 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r       <= ST_IDLE;
      pc_r       <= '0;
      word_r     <= '0;
      fcnt_r     <= 5'h0;
      dcnt_r     <= 32'h0;
      rep_r      <= 20'h0;
      loop_r     <= 20'h0;
      ret_r      <= '0;
      pat_r      <= 24'h0;
      rst_flag_r <= 1'b1;
      loop_act_r <= 1'b0;
    end else if (rst_any) begin
      st_r       <= ST_IDLE;
      pc_r       <= '0;
      rst_flag_r <= 1'b0;
      loop_act_r <= 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: if (sw_start || trig) begin
          st_r   <= ST_FETCH;
          pc_r   <= '0;
          fcnt_r <= FETCH_CYC;
        end
        ST_FETCH: begin
          word_r <= mem[pc_r];
          fcnt_r <= fcnt_r - 5'h1;
          if (fcnt_r == 5'h1) begin
            // Fetch plus delay plus overhead sets the shortest time.
            st_r <= (mem[pc_r].opcode == OP_STOP) ? ST_HALT : ST_TIME;
            if (mem[pc_r].opcode != OP_STOP) begin
              pat_r  <= mem[pc_r].pattern;
              dcnt_r <= mem[pc_r].delay;
              rep_r  <= mem[pc_r].data;
            end
          end
        end
        ST_TIME: begin
          dcnt_r <= dcnt_r - 32'h1;
          if (dly_end) begin
            if (opc == OP_LONG && !rep_end) begin
              rep_r  <= rep_r - 20'h1;
              dcnt_r <= word_r.delay;
            end else if (opc == OP_WAIT) begin
              st_r <= ST_WAIT;
            end else begin
              // Jumping back onto the loop's own start must not reload the count.
              if (opc == OP_LOOP && !loop_act_r) begin
                loop_r <= word_r.data;
              end
              if (opc == OP_LOOP) begin
                loop_act_r <= 1'b1;
              end
              if (opc == OP_END_LOOP) begin
                loop_r <= loop_r - 20'h1;
                if (loop_ex) loop_act_r <= 1'b0;
              end
              if (opc == OP_CALL) ret_r <= pc_r + 1'b1;
              pc_r   <= pc_nxt;
              st_r   <= ST_FETCH;
              fcnt_r <= FETCH_CYC;
            end
          end
        end
        ST_WAIT: if (trig) begin
          pc_r   <= pc_r + 1'b1;
          st_r   <= ST_FETCH;
          fcnt_r <= FETCH_CYC;
        end
        ST_HALT: ;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign pattern_o     = pat_r;
  assign running_o     = (st_r == ST_FETCH) || (st_r == ST_TIME) || (st_r == ST_WAIT);
  assign waiting_o     = (st_r == ST_WAIT);
  assign reset_state_o = rst_flag_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_fetch_done;
    st_r == ST_FETCH && fcnt_r == 5'h1 && mem[pc_r].opcode != OP_STOP;
  endsequence

  // A delay count of the current word runs out; unless the word is OP_WAIT or a repeating OP_LONG, the next address is chosen here.
  sequence s_step_end;
    st_r == ST_TIME && dly_end && !rst_any;
  endsequence

  pattern_load_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (s_fetch_done and !rst_any) |=> pattern_o == $past(mem[pc_r].pattern))
    else $error("Pattern not loaded at interval start.");
  halt_holds_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    st_r == ST_HALT && !rst_any |=> st_r == ST_HALT && $stable(pattern_o))
    else $error("Halt left or pattern moved.");
  wait_status_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    waiting_o |-> running_o)
    else $error("Waiting without running.");
  xrst_idle_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    xrst_lvl |=> st_r == ST_IDLE && pc_r == '0)
    else $error("External reset did not idle.");
  idle_start_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    st_r == ST_IDLE && sw_start && !rst_any |=> st_r == ST_FETCH && pc_r == '0)
    else $error("Start did not begin at first word.");
  wait_resume_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    st_r == ST_WAIT && trig && !rst_any |=> st_r == ST_FETCH && pc_r == $past(pc_r) + 1'b1)
    else $error("Wait did not resume at next word.");
  branch_tgt_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (s_step_end and opc == OP_BRANCH) |=> pc_r == $past(tgt))
    else $error("Branch target wrong.");
  // Two fetch cycles plus the shortest timed interval of three give the five-cycle minimum.
  min_time_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    st_r == ST_IDLE && sw_start && !rst_any ##1 !rst_any |-> st_r == ST_FETCH [*2])
    else $error("Fetch shorter than two cycles.");
  loop_exit_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (s_step_end and (opc == OP_END_LOOP && loop_ex))
    |=> pc_r == $past(pc_r) + 1'b1 && !loop_act_r)
    else $error("Exhausted loop did not fall through.");
  loop_back_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (s_step_end and (opc == OP_END_LOOP && !loop_ex))
    |=> pc_r == $past(tgt) && loop_r == $past(loop_r) - 20'h1)
    else $error("Loop end did not jump back and count down.");
  loop_keep_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (s_step_end and (opc == OP_LOOP && loop_act_r)) |=> $stable(loop_r))
    else $error("Loop count reloaded on re-entry.");
  call_ret_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (s_step_end and opc == OP_CALL) |=> pc_r == $past(tgt) && ret_r == $past(pc_r) + 1'b1)
    else $error("Call did not jump or save return point.");
  return_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (s_step_end and opc == OP_RETURN) |=> pc_r == $past(ret_r))
    else $error("Return did not resume after call.");
  long_rep_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (s_step_end and (opc == OP_LONG && !rep_end))
    |=> st_r == ST_TIME && pc_r == $past(pc_r) && dcnt_r == $past(word_r.delay))
    else $error("Long delay did not repeat its count.");
endmodule : pps_sequencer

/* src/pps_defines.svh */
// Offsets, field positions, control bits and timing counts of the pulse program sequencer.
// Assumes inclusion by bare name; holds definitions only.
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

`define PPS_OUT_LSB       0
`define PPS_OUT_W         24
`define PPS_DATA_LSB      24
`define PPS_DATA_W        20
`define PPS_OPC_LSB       44
`define PPS_OPC_W         4
`define PPS_DLY_LSB       48
`define PPS_DLY_W         32
`define PPS_WORD_W        80
`define PPS_OVERHEAD_CYC  3
`define PPS_MIN_CYC_INT   5
`define PPS_MIN_CYC_EXT   9
`define PPS_DEPTH_DEF     4096

`define PPS_REG_CTRL      12'h000
`define PPS_REG_STATUS    12'h004
`define PPS_REG_PADDR     12'h008
`define PPS_REG_PW0       12'h00c
`define PPS_REG_PW1       12'h010
`define PPS_REG_PW2       12'h014

`define PPS_CTRL_START    0
`define PPS_CTRL_RESET    1
`define PPS_CTRL_TRIG     2
`define PPS_CTRL_LOAD     3

`endif

/* src/pps_pkg.sv */
// Types shared by the pulse program sequencer files.
// Assumes the defines header is available on the include path.
`include "pps_defines.svh"
package pps_pkg;
  typedef enum logic [3:0] {
    OP_CONTINUE = 4'h0,
    OP_STOP     = 4'h1,
    OP_LOOP     = 4'h2,
    OP_END_LOOP = 4'h3,
    OP_CALL     = 4'h4,
    OP_RETURN   = 4'h5,
    OP_BRANCH   = 4'h6,
    OP_LONG     = 4'h7,
    OP_WAIT     = 4'h8
  } pps_opcode_t;

  typedef struct packed {
    logic [`PPS_DLY_W-1:0]  delay;
    logic [`PPS_OPC_W-1:0]  opcode;
    logic [`PPS_DATA_W-1:0] data;
    logic [`PPS_OUT_W-1:0]  pattern;
  } pps_word_t;

  typedef struct packed {
    logic running;
    logic waiting;
    logic reset_state;
    logic stopped;
  } pps_status_t;
endpackage : pps_pkg

/* src/pps_pin_sync.sv */
// Three-flop synchroniser with agreement filter for external pins.
// Assumes the input is asynchronous to sys_clk_i.
`timescale 1ns/1ps
module pps_pin_sync
  import pps_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic [2:0] sync_r;
  logic       level_r;

  // The filtered level only moves when the second and third stages agree.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_r  <= {3{RST_VAL}};
      level_r <= RST_VAL;
    end else begin
      sync_r  <= {sync_r[1:0], pin_i};
      if (sync_r[1] == sync_r[2]) begin
        level_r <= sync_r[2];
      end
    end
  end

  assign level_o = level_r;
endmodule : pps_pin_sync

/* verification/pps_pin_model.sv */
// Model of the external trigger and reset sources wired to the sequencer's pins.
// Assumes both pins are pulled high on the board and are driven low only when asserted.
`timescale 1ns/1ps
module pps_pin_model (
  input  wire logic sys_clk_i,
  output logic      trig_n_o,
  output logic      rst_n_o
);
  // The pull-ups hold both pins high whenever no source pulls them low.
  initial begin
    trig_n_o = 1'b1;
    rst_n_o  = 1'b1;
  end

  // The pulse is held for several cycles so that the agreement filter cannot miss it.
  task pulse_trig(input int n);
    @(posedge sys_clk_i) trig_n_o <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
    trig_n_o <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
  endtask : pulse_trig

  task pulse_reset(input int n);
    @(posedge sys_clk_i) rst_n_o <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
    rst_n_o <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
  endtask : pulse_reset
endmodule : pps_pin_model

/* verification/pulse_program_sequencer_bench.sv */
// Self-checking bench for the sequencer: loads a program over APB and times its pattern steps.
// Assumes the small DEPTH of 16 words set below; APB answers are awaited, never counted on.
`timescale 1ns/1ps
module pulse_program_sequencer_bench;
  import pps_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        arst_n_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, trig_n, rst_n;
  logic [23:0] pattern_o;
  logic        running_o, waiting_o, reset_state_o;
  int          num_errors = 0;
  int          checked    = 0;
  int          cyc        = 0;
  logic [23:0] last_pat   = 24'h0;
  logic [23:0] pat_q[$];
  int          tim_q[$];
  logic [31:0] rd;
  logic        er;

  always #5 sys_clk_i = ~sys_clk_i;

  pps_sequencer #(.DEPTH(16)) u_dut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .external_trigger_in_n_i(trig_n),
    .external_reset_in_n_i(rst_n), .pattern_o(pattern_o), .running_o(running_o),
    .waiting_o(waiting_o), .reset_state_o(reset_state_o));

  pps_pin_model u_pins (.sys_clk_i(sys_clk_i), .trig_n_o(trig_n), .rst_n_o(rst_n));

  // Every change of the pattern is logged with its cycle, so step lengths can be judged.
  always @(posedge sys_clk_i) begin
    cyc      <= cyc + 1;
    last_pat <= pattern_o;
    if (arst_n_i && pattern_o !== last_pat) begin
      pat_q.push_back(pattern_o);
      tim_q.push_back(cyc);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task conclude;
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i) penable_i <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk_i);
      if (pready_o === 1'b1) break;
    end
    if (pready_o !== 1'b1) num_errors++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // All fields get defined values, ignored ones included.
  task ld(input logic [3:0] op, input logic [19:0] dt, input logic [23:0] p,
          input logic [31:0] dl);
    pps_word_t w;
    w = '{delay: dl, opcode: op, data: dt, pattern: p};
    apb(1'b1, 12'h00c, w[31:0]);
    apb(1'b1, 12'h010, w[63:32]);
    apb(1'b1, 12'h014, {16'h0, w[79:64]});
    apb(1'b1, 12'h000, 32'h8);
  endtask : ld

  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk(pattern_o, 24'h0);
    chk({running_o, waiting_o, reset_state_o}, 3'b001);
    apb(1'b0, 12'h020, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
  endtask : t_reset

  // The step before the wait lasts longer than the minimum, and delays stay at 2 or more.
  task t_load;
    apb(1'b1, 12'h008, 32'h0);
    ld(4'h0, 20'h0, 24'h000011, 32'h4);
    ld(4'h2, 20'h2, 24'h000022, 32'h2);
    ld(4'h3, 20'h1, 24'h000033, 32'h2);
    ld(4'h4, 20'h7, 24'h000044, 32'h2);
    ld(4'h7, 20'h3, 24'h000055, 32'h2);
    ld(4'h6, 20'h8, 24'h000066, 32'h4);
    ld(4'h0, 20'h0, 24'h000000, 32'h2);
    ld(4'h5, 20'h0, 24'h000077, 32'h2);
    ld(4'h8, 20'h0, 24'h000088, 32'h6);
    ld(4'h1, 20'h0, 24'h000099, 32'h2);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'ha);
  endtask : t_load

  task t_run;
    logic [23:0] ep[10];
    int          el[9];
    int          i;
    ep = '{24'h11, 24'h22, 24'h33, 24'h22, 24'h33, 24'h44, 24'h77, 24'h55, 24'h66, 24'h88};
    el = '{7, 5, 5, 5, 5, 5, 5, 11, 7};
    apb(1'b1, 12'h000, 32'h1);
    for (i = 0; i < 400 && waiting_o !== 1'b1; i++) @(posedge sys_clk_i);
    chk({running_o, waiting_o}, 2'b11);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'hc, 32'hc);
    u_pins.pulse_trig(8);
    for (i = 0; i < 100 && running_o !== 1'b0; i++) @(posedge sys_clk_i);
    chk(pattern_o, 24'h88);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'hd, 32'h1);
    chk(pat_q.size(), 10);
    for (i = 0; i < 10 && i < pat_q.size(); i++) begin
      chk(pat_q[i], ep[i]);
      if (i < 9 && i + 1 < tim_q.size())
        chk(tim_q[i+1] - tim_q[i], el[i]);
    end
  endtask : t_run

  task t_restart;
    int i;
    u_pins.pulse_trig(8);
    repeat (20) @(posedge sys_clk_i);
    chk({running_o, pattern_o}, {1'b0, 24'h88});
    u_pins.pulse_reset(8);
    chk(reset_state_o, 1'b0);
    apb(1'b1, 12'h000, 32'h4);
    for (i = 0; i < 50 && pattern_o !== 24'h11; i++) @(posedge sys_clk_i);
    chk({running_o, pattern_o}, {1'b1, 24'h11});
    u_pins.pulse_reset(8);
    chk(running_o, 1'b0);
    u_pins.pulse_trig(8);
    for (i = 0; i < 50 && pattern_o !== 24'h22; i++) @(posedge sys_clk_i);
    chk({running_o, pattern_o}, {1'b1, 24'h22});
  endtask : t_restart

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n_i  <= 1'b0;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    pwrite_i  <= 1'b0;
    paddr_i   <= 12'h000;
    pwdata_i  <= 32'h0;
    repeat (12) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    t_reset;
    t_load;
    t_run;
    t_restart;
    conclude;
  end

  // The whole run needs about 330 cycles; the limit of 20000 cycles means a hang.
  initial begin
    #200000;
    num_errors++;
    conclude;
  end
endmodule : pulse_program_sequencer_bench
